/* File: verilog/hbp_consts.svh */
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH
// ==========================================================
// timing
`define HBP_CLK_PERIOD_NS 8
`define HBP_WAIT_MAX_NS 110
`define HBP_WAIT_MAX_CYC (`HBP_WAIT_MAX_NS / `HBP_CLK_PERIOD_NS)
`define HBP_SO_HZ_NS 75
`define HBP_SO_HZ_CYC (`HBP_SO_HZ_NS / `HBP_CLK_PERIOD_NS)
// ==========================================================
// reset values
`define HBP_PIN_RST 40'hF0_0000_0000
`define HBP_SER_PIN_RST 3'h1
`define HBP_WORD_RST 16'h0000
// ==========================================================
// serial frame layout, counted in sampled bits
`define HBP_SER_OP_LAST 6'h07
`define HBP_SER_RD_BIT 7
`define HBP_SER_ADDR_LAST 6'h17
`define HBP_SER_RD_DATA 6'h20
`define HBP_SER_WR_DATA 6'h18
`define HBP_SER_WORD_LAST 6'h0F
`endif

/* File: verilog/hbp_pkg.sv */
package hbp_pkg;
    typedef logic [15:0] hbp_word_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ACTIVE} hbp_state_e;
endpackage : hbp_pkg

/* File: verilog/hbp_serial.sv */
`timescale 1ns/1ps
`include "hbp_consts.svh"
// serial host port: opcode byte (bit 7 set = read), 16-bit word address,
// then words; reads carry one dummy byte before data
module hbp_serial import hbp_pkg::*; (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic pin_sck,
    input wire logic pin_si,
    input wire logic pin_ce_n,
    input wire logic rvalid,
    input wire hbp_word_t rdata,
    output logic so,
    output logic so_oe,
    output logic req_rd,
    output logic req_wr,
    output hbp_word_t req_addr,
    output hbp_word_t req_wdata
);
    // ==========================================================
    // pin synchronisers
    logic [2:0] s1_q, s2_q;
    logic sck_prev_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q <= `HBP_SER_PIN_RST;
            s2_q <= `HBP_SER_PIN_RST;
            sck_prev_q <= 1'h0;
        end else if (clk_en) begin
            s1_q <= {pin_sck, pin_si, pin_ce_n};
            s2_q <= s1_q;
            sck_prev_q <= s2_q[2];
        end
    end

    // edge decode on synchronised pins
    wire rise_w = s2_q[2] & ~sck_prev_q;
    wire fall_w = ~s2_q[2] & sck_prev_q;
    wire ce_off_w = s2_q[0];

    // ==========================================================
    // frame engine
    logic [5:0] cnt_q;
    logic rd_q;
    hbp_word_t sh_q, addr_q, nxt_q, obuf_q;
    wire [5:0] dstart_w = rd_q ? `HBP_SER_RD_DATA : `HBP_SER_WR_DATA;
    wire [5:0] dlast_w = 6'(dstart_w + `HBP_SER_WORD_LAST);
    wire hbp_word_t shin_w = {sh_q[14:0], s2_q[1]};
    wire hbp_word_t addr_inc_w = 16'(addr_q + 16'h0001);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 6'h00;
            rd_q <= 1'h0;
            sh_q <= `HBP_WORD_RST;
            addr_q <= `HBP_WORD_RST;
            nxt_q <= `HBP_WORD_RST;
            obuf_q <= `HBP_WORD_RST;
            so <= 1'h0;
            so_oe <= 1'h0;
            req_rd <= 1'h0;
            req_wr <= 1'h0;
            req_addr <= `HBP_WORD_RST;
            req_wdata <= `HBP_WORD_RST;
        end else if (clk_en) begin
            req_rd <= 1'h0;
            req_wr <= 1'h0;
            if (rvalid) begin
                nxt_q <= rdata;
            end
            if (ce_off_w) begin
                // frame over: release output at once
                cnt_q <= 6'h00;
                rd_q <= 1'h0;
                so_oe <= 1'h0; // R10
            end else begin
                if (rise_w) begin
                    sh_q <= shin_w; // R8
                    if (cnt_q == `HBP_SER_OP_LAST) begin
                        rd_q <= shin_w[`HBP_SER_RD_BIT];
                    end
                    if (cnt_q == `HBP_SER_ADDR_LAST) begin
                        addr_q <= shin_w;
                        req_rd <= rd_q;
                        req_addr <= shin_w;
                    end
                    if (cnt_q == dlast_w && !rd_q) begin
                        req_wr <= 1'h1;
                        req_addr <= addr_q;
                        req_wdata <= shin_w;
                        addr_q <= addr_inc_w;
                    end
                    cnt_q <= (cnt_q == dlast_w) ? dstart_w : 6'(cnt_q + 6'h01);
                end
                if (fall_w && rd_q && cnt_q >= dstart_w) begin
                    so_oe <= 1'h1;
                    if (cnt_q == dstart_w) begin
                        // word boundary: present prefetched word, fetch next
                        so <= nxt_q[15]; // R9
                        obuf_q <= {nxt_q[14:0], 1'h0};
                        req_rd <= 1'h1;
                        req_addr <= addr_inc_w;
                        addr_q <= addr_inc_w;
                    end else begin
                        so <= obuf_q[15]; // R9
                        obuf_q <= {obuf_q[14:0], 1'h0};
                    end
                end
            end
        end
    end

    // ==========================================================
    // checks
    a_si_on_rise: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        $changed(sh_q) |-> $past(rise_w)) else $error("serial input taken off a rising edge"); // R8
    a_so_on_fall: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        !$past(fall_w) |-> $stable(so)) else $error("serial output moved off a falling edge"); // R9
    a_so_release: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        $rose(ce_off_w) |-> ##[0:1] !so_oe) else $error("serial output not released"); // R10
endmodule : hbp_serial

/* File: verilog/hbp_host_port.sv */
`timescale 1ns/1ps
`include "hbp_consts.svh"
// ==========================================================
// What this block does and what the host must do
// R1: host reads with output enable and writes with write enable when style is 1.
// R2: host uses the common strobe plus a read/write select when style is 0.
// R3: wait stays inactive during every write access.
// R4: first or non-sequential read asserts wait until data, at most 110 ns.
// R5: next location is prefetched so sequential reads need no wait.
// R6: narrow mode moves each word as two byte accesses, low byte first.
// R7: wide-mode sequential word writes take the same timing as one write.
// R8: serial input is sampled on the serial clock rising edge.
// R9: serial output changes after each serial clock falling edge.
// R10: serial output released within 75 ns of chip enable going inactive.
// R11: host frames serial instructions with chip enable, idle at least 100 ns.
// R12: host keeps the serial clock period at 50 ns or more.
// R13: only address equal to last plus one is sequential; else restart with wait.
module hbp_host_port import hbp_pkg::*; (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic pin_ce_n,
    input wire logic pin_oe_n,
    input wire logic pin_we_n,
    input wire logic pin_host_common_strobe_n,
    input wire logic pin_rw_read,
    input wire logic pin_bus_style_select,
    input wire logic pin_bus_width16,
    input wire logic pin_serial_sel,
    input wire hbp_word_t pin_addr,
    input wire hbp_word_t pin_data_in,
    input wire logic pin_sck,
    input wire logic pin_si,
    input wire hbp_word_t mem_rdata,
    input wire logic mem_rvalid,
    output hbp_word_t data_out,
    output logic data_oe,
    output logic wait_n,
    output logic so,
    output logic so_oe,
    output logic mem_rd,
    output logic mem_wr,
    output hbp_word_t mem_addr,
    output hbp_word_t mem_wdata
);
    // strobe decode for either bus style
    function automatic logic hbp_dir(input logic style, input logic ce_n, input logic oe_n,
                                     input logic we_n, input logic str_n, input logic rw, input logic rd);
        if (style) begin
            hbp_dir = !ce_n && (rd ? !oe_n : !we_n); // R1
        end else begin
            hbp_dir = !ce_n && !str_n && (rw == rd); // R2
        end
    endfunction : hbp_dir

    // byte address to word address in narrow mode
    function automatic hbp_word_t hbp_waddr(input logic bw16, input hbp_word_t a);
        hbp_waddr = bw16 ? a : {1'h0, a[15:1]};
    endfunction : hbp_waddr

    // ==========================================================
    // pin synchronisers
    logic [39:0] s1_q, s2_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q <= `HBP_PIN_RST;
            s2_q <= `HBP_PIN_RST;
        end else if (clk_en) begin
            s1_q <= {pin_ce_n, pin_oe_n, pin_we_n, pin_host_common_strobe_n, pin_rw_read,
                     pin_bus_style_select, pin_bus_width16, pin_serial_sel, pin_addr, pin_data_in};
            s2_q <= s1_q;
        end
    end

    // ==========================================================
    // access decode
    wire ser_sel_w = s2_q[32];
    wire bw16_w = s2_q[33];
    wire hbp_word_t addr_w = s2_q[31:16];
    wire hbp_word_t din_w = s2_q[15:0];
    wire rd_lvl_w = !ser_sel_w && hbp_dir(s2_q[34], s2_q[39], s2_q[38], s2_q[37], s2_q[36], s2_q[35], 1'h1);
    wire wr_lvl_w = !ser_sel_w && hbp_dir(s2_q[34], s2_q[39], s2_q[38], s2_q[37], s2_q[36], s2_q[35], 1'h0);
    logic rd_prev_q, wr_prev_q;
    wire rd_rise_w = rd_lvl_w && !rd_prev_q;
    wire wr_rise_w = wr_lvl_w && !wr_prev_q;

    // prefetch buffer state
    hbp_state_e state_q;
    logic buf_valid_q, pend_q, last_valid_q;
    hbp_word_t buf_q, buf_waddr_q, last_addr_q, req_addr_q;
    logic [7:0] lo_hold_q;
    wire hbp_word_t waddr_w = hbp_waddr(bw16_w, addr_w);
    wire hbp_word_t req_waddr_w = hbp_waddr(bw16_w, req_addr_q);
    wire seq_w = last_valid_q && (addr_w == 16'(last_addr_q + 16'h0001)); // R13
    wire hit_w = seq_w && buf_valid_q && (buf_waddr_q == waddr_w);
    wire req_hit_w = buf_valid_q && (buf_waddr_q == req_waddr_w);
    wire last_byte_w = bw16_w || req_addr_q[0];
    wire hbp_word_t rd_sel_w = bw16_w ? buf_q : {8'h00, req_addr_q[0] ? buf_q[15:8] : buf_q[7:0]};

    // serial engine
    logic ser_rd_w, ser_wr_w;
    hbp_word_t ser_addr_w, ser_wdata_w;
    hbp_serial u_serial (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clk_en(clk_en),
        .pin_sck(pin_sck),
        .pin_si(pin_si),
        .pin_ce_n(pin_ce_n),
        .rvalid(mem_rvalid && ser_sel_w),
        .rdata(mem_rdata),
        .so(so),
        .so_oe(so_oe),
        .req_rd(ser_rd_w),
        .req_wr(ser_wr_w),
        .req_addr(ser_addr_w),
        .req_wdata(ser_wdata_w)
    );

    // ==========================================================
    // parallel access engine; later assignments override the fill
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            rd_prev_q <= 1'h0;
            wr_prev_q <= 1'h0;
            buf_valid_q <= 1'h0;
            pend_q <= 1'h0;
            last_valid_q <= 1'h0;
            buf_q <= `HBP_WORD_RST;
            buf_waddr_q <= `HBP_WORD_RST;
            last_addr_q <= `HBP_WORD_RST;
            req_addr_q <= `HBP_WORD_RST;
            lo_hold_q <= 8'h00;
            data_out <= `HBP_WORD_RST;
            data_oe <= 1'h0;
            wait_n <= 1'h1;
            mem_rd <= 1'h0;
            mem_wr <= 1'h0;
            mem_addr <= `HBP_WORD_RST;
            mem_wdata <= `HBP_WORD_RST;
        end else if (clk_en) begin
            rd_prev_q <= rd_lvl_w;
            wr_prev_q <= wr_lvl_w;
            mem_rd <= 1'h0;
            mem_wr <= 1'h0;
            if (mem_rvalid && pend_q) begin
                buf_q <= mem_rdata;
                buf_waddr_q <= mem_addr;
                buf_valid_q <= 1'h1;
                pend_q <= 1'h0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (rd_rise_w) begin
                        req_addr_q <= addr_w;
                        last_addr_q <= addr_w;
                        last_valid_q <= 1'h1;
                        wait_n <= hit_w; // R4
                        state_q <= ST_FETCH;
                        if (!seq_w) begin
                            // non-sequential: drop prefetch, fetch afresh
                            buf_valid_q <= 1'h0; // R13
                            pend_q <= 1'h1;
                            mem_rd <= 1'h1;
                            mem_addr <= waddr_w;
                        end
                    end else if (wr_rise_w) begin
                        // writes never wait and drop any prefetched word
                        buf_valid_q <= 1'h0;
                        pend_q <= 1'h0;
                        last_valid_q <= 1'h0;
                        state_q <= ST_ACTIVE; // R3
                        if (bw16_w || addr_w[0]) begin
                            mem_wr <= 1'h1; // R7
                            mem_addr <= waddr_w;
                            mem_wdata <= bw16_w ? din_w : {din_w[7:0], lo_hold_q}; // R6
                        end else begin
                            lo_hold_q <= din_w[7:0]; // R6
                        end
                    end
                end
                ST_FETCH: begin
                    if (!rd_lvl_w) begin
                        wait_n <= 1'h1;
                        state_q <= ST_IDLE;
                    end else if (req_hit_w) begin
                        data_out <= rd_sel_w;
                        data_oe <= 1'h1;
                        wait_n <= 1'h1; // R4
                        state_q <= ST_ACTIVE;
                        if (last_byte_w) begin
                            // word consumed: prefetch the following one
                            buf_valid_q <= 1'h0; // R5
                            pend_q <= 1'h1;
                            mem_rd <= 1'h1;
                            mem_addr <= 16'(req_waddr_w + 16'h0001);
                        end
                    end else if (!pend_q) begin
                        pend_q <= 1'h1;
                        mem_rd <= 1'h1;
                        mem_addr <= req_waddr_w;
                    end
                end
                ST_ACTIVE: begin
                    if (!rd_lvl_w && !wr_lvl_w) begin
                        data_oe <= 1'h0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            // serial mode owns the memory port
            if (ser_sel_w) begin
                pend_q <= 1'h0;
                buf_valid_q <= 1'h0;
                mem_rd <= ser_rd_w;
                mem_wr <= ser_wr_w;
                mem_addr <= ser_addr_w;
                mem_wdata <= ser_wdata_w;
            end
        end
    end

    // ==========================================================
    // checks; wait_cnt_q is helper logic for the wait bound
    localparam int WAIT_MAX = `HBP_WAIT_MAX_CYC;
    logic [4:0] wait_cnt_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wait_cnt_q <= 5'h00;
        end else if (clk_en) begin
            wait_cnt_q <= wait_n ? 5'h00 : 5'(wait_cnt_q + 5'h01);
        end
    end

    a_no_wait_write: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        wr_lvl_w && state_q != ST_FETCH |=> wait_n) else $error("wait during write"); // R3
    a_wait_bound: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        wait_cnt_q <= 5'(WAIT_MAX)) else $error("wait held too long"); // R4
    a_wait_until_data: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        $rose(wait_n) && rd_lvl_w |-> data_oe || state_q == ST_ACTIVE) else $error("wait ended without data"); // R4
    a_seq_no_wait: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        state_q == ST_IDLE && rd_rise_w && hit_w && !ser_sel_w |=> wait_n ##1 data_oe)
        else $error("sequential read waited"); // R5
    a_prefetch_next: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        state_q == ST_FETCH && rd_lvl_w && req_hit_w && last_byte_w && !ser_sel_w
        |=> mem_rd && mem_addr == 16'($past(req_waddr_w) + 16'h0001)) else $error("no prefetch"); // R5
    a_byte_pair: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        state_q == ST_IDLE && wr_rise_w && !bw16_w && !ser_sel_w |=> mem_wr == $past(addr_w[0]))
        else $error("byte pair write wrong"); // R6
    a_word_write: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        state_q == ST_IDLE && wr_rise_w && bw16_w && !ser_sel_w |=> mem_wr && mem_wdata == $past(din_w))
        else $error("word write not taken"); // R7
    a_nonseq_wait: assert property (@(posedge clk_sys) disable iff (!rstn || !clk_en)
        state_q == ST_IDLE && rd_rise_w && !seq_w && !ser_sel_w |=> !wait_n && mem_rd)
        else $error("non-sequential read did not restart"); // R13
endmodule : hbp_host_port

/* File: verif/hbp_mem_model.sv */
`timescale 1ns/1ps
// ==========================================================
// memory behind the port: answers exactly one cycle after a read strobe
module hbp_mem_model import hbp_pkg::*; (
    input wire logic clk_sys,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire hbp_word_t mem_addr,
    input wire hbp_word_t mem_wdata,
    output logic mem_rvalid,
    output hbp_word_t mem_rdata
);
    hbp_word_t mem [0:255];
    // preload a pattern the bench can recompute on its own
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {i[7:0] ^ 8'h5A, i[7:0]};
        end
    end
    // outside a valid cycle the data bus toggles, so stale data never looks right
    always @(posedge clk_sys) begin
        if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
        mem_rvalid <= mem_rd;
        mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
    end
endmodule : hbp_mem_model

/* File: verif/host_bus_port_timing_test.sv */
`timescale 1ns/1ps
module host_bus_port_timing_test import hbp_pkg::*;;
    logic clk_sys, rstn, pin_ce_n, pin_oe_n, pin_we_n, pin_host_common_strobe_n, pin_rw_read;
    logic pin_bus_style_select, pin_bus_width16, pin_serial_sel, pin_sck, pin_si;
    hbp_word_t pin_addr, pin_data_in, mem_rdata, data_out, mem_addr, mem_wdata;
    logic mem_rvalid, data_oe, wait_n, so, so_oe, mem_rd, mem_wr;
    int err_total = 0;
    int n_compared = 0;
    // ==========================================================
    // design and memory partner
    hbp_host_port hbp_host_port_i (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .pin_ce_n(pin_ce_n),
        .pin_oe_n(pin_oe_n), .pin_we_n(pin_we_n), .pin_host_common_strobe_n(pin_host_common_strobe_n),
        .pin_rw_read(pin_rw_read), .pin_bus_style_select(pin_bus_style_select),
        .pin_bus_width16(pin_bus_width16), .pin_serial_sel(pin_serial_sel), .pin_addr(pin_addr),
        .pin_data_in(pin_data_in), .pin_sck(pin_sck), .pin_si(pin_si), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .data_out(data_out), .data_oe(data_oe), .wait_n(wait_n), .so(so),
        .so_oe(so_oe), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    hbp_mem_model hbp_mem_model_i (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    // ==========================================================
    // clock and reporting
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic hbp_word_t pat(input hbp_word_t a);
        return {a[7:0] ^ 8'h5A, a[7:0]};
    endfunction : pat
    task automatic bad(input string m);
        err_total++;
        $display("BAD t=%0t %s", $time, m);
    endtask : bad
    task automatic cmp(input hbp_word_t got, input hbp_word_t exp, input string m);
        n_compared++;
        if (got !== exp) bad($sformatf("%s got %h want %h", m, got, exp));
    endtask : cmp
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // ==========================================================
    // parallel host cycles, strobes held until the answer is taken
    task automatic par_go(input logic wr, input hbp_word_t a, input hbp_word_t d);
        @(negedge clk_sys);
        pin_addr = a;
        pin_data_in = d;
        pin_rw_read = !wr;
        pin_ce_n = 1'b0;
        if (pin_bus_style_select) begin
            if (wr) pin_we_n = 1'b0;
            else pin_oe_n = 1'b0;
        end else pin_host_common_strobe_n = 1'b0;
    endtask : par_go
    // idle long enough for the synchronised release and a pending prefetch
    task automatic par_end;
        @(negedge clk_sys);
        pin_oe_n = 1'b1;
        pin_we_n = 1'b1;
        pin_host_common_strobe_n = 1'b1;
        pin_ce_n = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask : par_end
    task automatic par_write(input hbp_word_t a, input hbp_word_t d);
        par_go(1'b1, a, d);
        n_compared++;
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            if (wait_n !== 1'b1) bad("wait asserted in write");
        end
        par_end();
    endtask : par_write
    task automatic par_read(input hbp_word_t a, input hbp_word_t exp, input logic want_wait);
        int wl;
        int k;
        par_go(1'b0, a, 16'h0000);
        wl = 0;
        for (k = 0; k < 30 && data_oe !== 1'b1; k++) begin
            @(negedge clk_sys);
            if (wait_n === 1'b0) wl++;
        end
        if (k == 30) begin
            bad("read never answered");
            conclude();
        end
        cmp(data_out, exp, "read data");
        n_compared++;
        if (want_wait && (wl < 1 || wl > 13)) bad("first read wait length");
        if (!want_wait && wl != 0) bad("wait on sequential read");
        par_end();
    endtask : par_read
    // ==========================================================
    // scenarios
    task automatic scen_wide_read;
        for (int s = 0; s < 2; s++) begin
            pin_bus_style_select = s[0];
            pin_bus_width16 = 1'b1;
            par_read(16'h0010 + 16'(s * 64), pat(16'h0010 + 16'(s * 64)), 1'b1);
            par_read(16'h0011 + 16'(s * 64), pat(16'h0011 + 16'(s * 64)), 1'b0);
            par_read(16'h0012 + 16'(s * 64), pat(16'h0012 + 16'(s * 64)), 1'b0);
            par_read(16'h0019 + 16'(s * 64), pat(16'h0019 + 16'(s * 64)), 1'b1);
            par_read(16'h001A + 16'(s * 64), pat(16'h001A + 16'(s * 64)), 1'b0);
        end
    endtask : scen_wide_read
    task automatic scen_wide_write;
        for (int s = 0; s < 2; s++) begin
            pin_bus_style_select = s[0];
            par_write(16'h0080 + 16'(s * 2), 16'h1234 ^ 16'(s));
            par_write(16'h0081 + 16'(s * 2), 16'hBEEF ^ 16'(s));
            cmp(hbp_mem_model_i.mem[8'h80 + 8'(s * 2)], 16'h1234 ^ 16'(s), "wide write");
            cmp(hbp_mem_model_i.mem[8'h81 + 8'(s * 2)], 16'hBEEF ^ 16'(s), "wide write next");
            par_read(16'h0081 + 16'(s * 2), 16'hBEEF ^ 16'(s), 1'b1);
        end
    endtask : scen_wide_write
    task automatic scen_narrow;
        hbp_word_t w;
        hbp_word_t p;
        pin_bus_width16 = 1'b0;
        for (int s = 0; s < 2; s++) begin
            pin_bus_style_select = s[0];
            w = 16'h0090 + 16'(s * 4);
            p = pat(w + 16'h0001);
            par_write({w[14:0], 1'b0}, 16'h00C1 + 16'(s));
            par_write({w[14:0], 1'b1}, 16'h007E - 16'(s));
            cmp(hbp_mem_model_i.mem[w[7:0]], {8'h7E - 8'(s), 8'hC1 + 8'(s)}, "byte pair word");
            par_read({w[14:0], 1'b0}, 16'h00C1 + 16'(s), 1'b1);
            par_read({w[14:0], 1'b1}, 16'h007E - 16'(s), 1'b0);
            par_read({w[14:0], 1'b0} + 16'h0002, {8'h00, p[7:0]}, 1'b0);
            par_read({w[14:0], 1'b1} + 16'h0002, {8'h00, p[15:8]}, 1'b0);
        end
        pin_bus_width16 = 1'b1;
    endtask : scen_narrow
    // ==========================================================
    // serial frames, mode 0, serial clock 88 ns and idle low between frames
    task automatic ser_bit(input logic b, output logic got);
        @(negedge clk_sys);
        pin_si = b;
        repeat (5) @(negedge clk_sys);
        got = so;
        pin_sck = 1'b1;
        // a high phase of 40 ns and a low phase of 48 ns keep the serial clock period legal
        repeat (5) @(negedge clk_sys);
        pin_sck = 1'b0;
    endtask : ser_bit
    task automatic ser_frame(input logic [7:0] op, input hbp_word_t a, input hbp_word_t wd, output hbp_word_t rd);
        logic [47:0] v;
        logic b;
        int n;
        int k;
        v = op[7] ? {op, a, 24'h00_0000} : {op, a, wd, 8'h00};
        n = op[7] ? 48 : 40;
        @(negedge clk_sys);
        pin_ce_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            ser_bit(v[47 - i], b);
            rd = {rd[14:0], b};
        end
        repeat (4) @(negedge clk_sys);
        if (op[7]) begin
            n_compared++;
            if (so_oe !== 1'b1) bad("serial out not driven in read");
        end
        pin_ce_n = 1'b1;
        pin_si = ~pin_si;
        for (k = 0; k < 12 && so_oe !== 1'b0; k++) @(negedge clk_sys);
        n_compared++;
        if (k > 9) bad("serial out not released in time");
        if (k == 12) conclude();
        repeat (13) @(negedge clk_sys);
    endtask : ser_frame
    task automatic scen_serial;
        hbp_word_t rd;
        pin_serial_sel = 1'b1;
        par_write(16'h00A0, 16'h5555);
        cmp(hbp_mem_model_i.mem[8'hA0], pat(16'h00A0), "parallel write while serial");
        ser_frame(8'h00, 16'h0020, 16'hC3A5, rd);
        cmp(hbp_mem_model_i.mem[8'h20], 16'hC3A5, "serial write");
        ser_frame(8'h80, 16'h0020, 16'h0000, rd);
        cmp(rd, 16'hC3A5, "serial read");
        ser_frame(8'h80, 16'h0033, 16'h0000, rd);
        cmp(rd, pat(16'h0033), "serial read pattern");
        pin_serial_sel = 1'b0;
    endtask : scen_serial
    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        {pin_ce_n, pin_oe_n, pin_we_n, pin_host_common_strobe_n} = 4'hF;
        {pin_rw_read, pin_bus_style_select, pin_bus_width16, pin_serial_sel} = 4'h6;
        {pin_sck, pin_si} = 2'b00;
        pin_addr = 16'h0000;
        pin_data_in = 16'h0000;
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        scen_wide_read();
        scen_wide_write();
        scen_narrow();
        scen_serial();
        conclude();
    end
endmodule : host_bus_port_timing_test
